// >>> src/hid_pkg.sv
package hid_pkg;

    // Descriptor word layout: bit positions within the 64-bit words.
    localparam int DW0_VALID_BIT   = 0;
    localparam int DW0_EPLOW_BIT   = 31;
    localparam int DW0_MULT_LSB    = 29;
    localparam int DW1_EPHIGH_LSB  = 32;
    localparam int DW1_FADDR_LSB   = 35;
    localparam int DW1_TOKEN_LSB   = 42;
    localparam int DW1_KIND_LSB    = 44;
    localparam int DW1_SPLIT_BIT   = 46;
    localparam int DW2_FRAME_LSB   = 3;
    localparam int DW2_BUF_LSB     = 8;
    localparam int DW3_COUNT_LSB   = 32;
    localparam int DW3_HALT_BIT    = 62;
    localparam int DW3_ACTIVE_BIT  = 63;
    localparam int DW4_MASK_LSB    = 0;
    localparam int DW4_RESULT_LSB  = 8;

    // Token encodings.
    localparam logic [1:0] TOKEN_OUT = 2'h0;
    localparam logic [1:0] TOKEN_IN  = 2'h1;

    // Result bit positions in one three-bit microframe result.
    localparam int RES_XACT_ERR = 0;
    localparam int RES_BABBLE   = 1;
    localparam int RES_UNDERRUN = 2;

    // Register offsets of the control port.
    localparam logic [3:0] REG_DW0    = 4'h0;
    localparam logic [3:0] REG_DW1    = 4'h1;
    localparam logic [3:0] REG_DW2    = 4'h2;
    localparam logic [3:0] REG_DW3    = 4'h3;
    localparam logic [3:0] REG_DW4    = 4'h4;
    localparam logic [3:0] REG_CTRL   = 4'h5;
    localparam logic [3:0] REG_IRQ_ST = 4'h6;
    localparam logic [3:0] REG_IRQ_EN = 4'h7;
    localparam logic [3:0] REG_IRQ_CL = 4'h8;

    // Interrupt status bit positions.
    localparam int IRQ_DONE = 0;
    localparam int IRQ_HALT = 1;
    localparam int IRQ_ERR  = 2;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Decoded transaction request toward the link engine.
    typedef struct packed {
        logic        split;
        logic [1:0]  token;
        logic [6:0]  function_addr;
        logic [3:0]  endpoint;
        logic [15:0] buffer_start_word;
        logic [2:0]  uframe;
    } hid_xact_t;

    // Outcome of one packet reported by the link engine.
    typedef struct packed {
        logic        stall;
        logic [2:0]  microframe_result;
        logic [11:0] bytes;
        logic        last;
    } hid_result_t;

endpackage : hid_pkg

// >>> src/hid_uframe_sched.sv
// Picks the microframe slots to execute within the descriptor's frame.
module hid_uframe_sched (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Frame matching.
    input  wire logic [4:0] desc_frame,
    input  wire logic [4:0] bus_frame,
    input  wire logic [2:0] bus_uframe,
    input  wire logic       uframe_tick,
    input  wire logic [7:0] microframe_enable_mask,
    // Result.
    output logic            slot_hit_q
);

    // A slot is due only when the frame matches and that microframe is enabled.
    wire frame_match = (desc_frame == bus_frame);
    wire enabled     = microframe_enable_mask[bus_uframe];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            slot_hit_q <= 1'b0;
        end else begin
            slot_hit_q <= uframe_tick & frame_match & enabled;
        end
    end

endmodule : hid_uframe_sched

// >>> src/hid_engine.sv
module hid_engine (
    // Clock and reset.
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    // Register port.
    input  wire logic [3:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [31:0]               reg_rdata_q,
    // Bus timing.
    input  wire logic [4:0]           bus_frame,
    input  wire logic [2:0]           bus_uframe,
    input  wire logic                 uframe_tick,
    // Link engine request.
    output hid_pkg::hid_xact_t        xact_q,
    output logic                      xact_req_q,
    input  wire logic                 xact_done,
    input  wire hid_pkg::hid_result_t xact_res,
    // Interrupt.
    output logic                      irq_q
);

    typedef enum logic [1:0] {
        HID_IDLE = 2'b00,
        HID_WAIT = 2'b01,
        HID_SEND = 2'b10,
        HID_BUSY = 2'b11
    } hid_state_t;

    // Every check below samples on the system clock and rests during reset.
    default clocking chk_clk @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor storage.

    // Descriptor words: 64-bit registers, written and read in 32-bit halves chosen by hi_sel_q.
    logic [63:0] dw0_q;
    logic [63:0] dw1_q;
    logic [63:0] dw2_q;
    logic [63:0] dw3_q;
    logic [63:0] dw4_q;
    logic        hi_sel_q;
    logic [2:0]  irq_st_q;
    logic [2:0]  irq_en_q;
    hid_state_t  state_q;
    logic [1:0]  pkt_cnt_q;
    logic [14:0] byte_acc_q;
    logic        slot_hit;

    // Field views of the descriptor.
    wire       valid_bit  = dw0_q[hid_pkg::DW0_VALID_BIT];
    wire       active_bit = dw3_q[hid_pkg::DW3_ACTIVE_BIT];
    wire       live       = valid_bit | active_bit;
    wire       halted     = dw3_q[hid_pkg::DW3_HALT_BIT];
    wire [1:0] mult       = dw0_q[hid_pkg::DW0_MULT_LSB +: 2];
    wire [2:0] endpoint_number_high = dw1_q[hid_pkg::DW1_EPHIGH_LSB +: 3];
    wire       endpoint_number_low  = dw0_q[hid_pkg::DW0_EPLOW_BIT];
    wire [3:0] endpoint   = {endpoint_number_high, endpoint_number_low};
    wire [4:0] desc_frame = dw2_q[hid_pkg::DW2_FRAME_LSB +: 5];
    wire [7:0] microframe_enable_mask = dw4_q[hid_pkg::DW4_MASK_LSB +: 8];
    wire [1:0] endpoint_kind = dw1_q[hid_pkg::DW1_KIND_LSB +: 2];

    // Register decode.
    wire        wr_lo    = reg_wr & ~reg_addr[3] & ~hi_sel_q;
    wire        wr_hi    = reg_wr & ~reg_addr[3] & hi_sel_q;
    wire        wr_ctrl  = reg_wr & (reg_addr == hid_pkg::REG_CTRL);
    wire        wr_en    = reg_wr & (reg_addr == hid_pkg::REG_IRQ_EN);
    wire        wr_clr   = reg_wr & (reg_addr == hid_pkg::REG_IRQ_CL);
    wire        sel_dw0  = reg_addr == hid_pkg::REG_DW0;
    wire        sel_dw1  = reg_addr == hid_pkg::REG_DW1;
    wire        sel_dw2  = reg_addr == hid_pkg::REG_DW2;
    wire        sel_dw3  = reg_addr == hid_pkg::REG_DW3;
    wire        sel_dw4  = reg_addr == hid_pkg::REG_DW4;
    wire [63:0] rd_word  = sel_dw0 ? dw0_q : sel_dw1 ? dw1_q : sel_dw2 ? dw2_q :
                           sel_dw3 ? dw3_q : sel_dw4 ? dw4_q : 64'h0;
    wire [31:0] rd_half  = hi_sel_q ? rd_word[63:32] : rd_word[31:0];
    // Unmapped indexes read as zero, so software never sees a stale word there.
    wire [31:0] rd_mux   = (reg_addr < hid_pkg::REG_CTRL) ? rd_half :
                           (reg_addr == hid_pkg::REG_CTRL) ? {31'h0, hi_sel_q} :
                           (reg_addr == hid_pkg::REG_IRQ_ST) ? {29'h0, irq_st_q} :
                           (reg_addr == hid_pkg::REG_IRQ_EN) ? {29'h0, irq_en_q} :
                           32'h0;

    // Engine events.
    wire        take_slot = (state_q == HID_WAIT) & slot_hit;
    wire        got_res   = (state_q == HID_BUSY) & xact_done;
    wire        stall_ev  = got_res & xact_res.stall;
    wire        fatal_ev  = got_res & xact_res.microframe_result[hid_pkg::RES_XACT_ERR];
    wire [14:0] acc_next  = byte_acc_q + {3'h0, xact_res.bytes};
    wire        mult_done = ({1'b0, pkt_cnt_q} + 3'h1) >= {1'b0, mult};
    wire        more_pkt  = got_res & ~xact_res.last & ~mult_done & ~stall_ev & ~fatal_ev;
    wire        slot_end  = got_res & ~more_pkt;
    // Enable bits clear as their slots run, so no other bit left, or microframe 7, means the last slot.
    wire        last_slot = ~|(microframe_enable_mask & ~(8'h1 << xact_q.uframe)) |
                            (xact_q.uframe == 3'h7);
    wire        finish_ev = slot_end & ~stall_ev & ~fatal_ev & last_slot;
    wire        retire    = stall_ev | fatal_ev | finish_ev;
    wire [2:0]  irq_ev    = {fatal_ev, stall_ev, finish_ev};
    wire [5:0]  res_pos   = 6'(hid_pkg::DW4_RESULT_LSB) + 6'(3 * xact_q.uframe);

    ////////////////////////////////////////////////////////////////////////////
    // Scheduler.

    hid_uframe_sched hid_uframe_sched_inst (
        .clk_sys                (clk_sys),
        .rst_n                  (rst_n),
        .desc_frame             (desc_frame),
        .bus_frame              (bus_frame),
        .bus_uframe             (bus_uframe),
        .uframe_tick            (uframe_tick),
        .microframe_enable_mask (microframe_enable_mask),
        .slot_hit_q             (slot_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control state machine.

    // A descriptor that is not live or is halted never leaves idle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= HID_IDLE;
        end else begin
            unique case (state_q)
                HID_IDLE: state_q <= (live & ~halted) ? HID_WAIT : HID_IDLE;
                HID_WAIT: state_q <= (~live | halted) ? HID_IDLE :
                                     slot_hit ? HID_SEND : HID_WAIT;
                HID_SEND: state_q <= HID_BUSY;
                HID_BUSY: state_q <= retire ? HID_IDLE :
                                     more_pkt ? HID_SEND :
                                     got_res ? HID_WAIT : HID_BUSY;
            endcase
        end
    end

    // Packet counter and byte accumulator for one execution.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pkt_cnt_q  <= 2'h0;
            byte_acc_q <= 15'h0;
        end else if (state_q == HID_IDLE) begin
            pkt_cnt_q  <= 2'h0;
            byte_acc_q <= 15'h0;
        end else if (got_res) begin
            pkt_cnt_q  <= more_pkt ? pkt_cnt_q + 2'h1 : 2'h0;
            byte_acc_q <= acc_next;
        end
    end

    // Request toward the link; fields copied from the descriptor, microframe from the bus.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xact_q     <= '0;
            xact_req_q <= 1'b0;
        end else begin
            xact_req_q <= (state_q == HID_SEND);
            if (state_q == HID_WAIT && slot_hit) begin
                xact_q.split             <= dw1_q[hid_pkg::DW1_SPLIT_BIT];
                xact_q.token             <= dw1_q[hid_pkg::DW1_TOKEN_LSB +: 2];
                xact_q.function_addr     <= dw1_q[hid_pkg::DW1_FADDR_LSB +: 7];
                xact_q.endpoint          <= endpoint;
                xact_q.buffer_start_word <= dw2_q[hid_pkg::DW2_BUF_LSB +: 16];
                xact_q.uframe            <= bus_uframe;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor words: software writes, hardware write-back.

    // Hardware updates override software writes in the same cycle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dw0_q    <= 64'h0;
            dw1_q    <= 64'h0;
            dw2_q    <= 64'h0;
            dw3_q    <= 64'h0;
            dw4_q    <= 64'h0;
            hi_sel_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                hi_sel_q <= reg_wdata[0];
            end
            if ((wr_lo | wr_hi) & sel_dw0) begin
                dw0_q[hi_sel_q*32 +: 32] <= reg_wdata;
            end
            if ((wr_lo | wr_hi) & sel_dw1) begin
                dw1_q[hi_sel_q*32 +: 32] <= reg_wdata;
            end
            if ((wr_lo | wr_hi) & sel_dw2) begin
                dw2_q[hi_sel_q*32 +: 32] <= reg_wdata;
            end
            if ((wr_lo | wr_hi) & sel_dw3) begin
                dw3_q[hi_sel_q*32 +: 32] <= reg_wdata;
            end
            if ((wr_lo | wr_hi) & sel_dw4) begin
                dw4_q[hi_sel_q*32 +: 32] <= reg_wdata;
            end
            if (got_res) begin
                dw3_q[hid_pkg::DW3_COUNT_LSB +: 15] <= acc_next;
                dw4_q[res_pos +: 3] <= xact_res.microframe_result;
            end
            if (slot_end) begin
                dw4_q[xact_q.uframe] <= 1'b0;
            end
            if (stall_ev) begin
                dw3_q[hid_pkg::DW3_HALT_BIT] <= 1'b1;
            end
            if (retire) begin
                dw0_q[hid_pkg::DW0_VALID_BIT]  <= 1'b0;
                dw3_q[hid_pkg::DW3_ACTIVE_BIT] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts and read data.

    // Status is sticky; a new event in the clear cycle wins.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_st_q    <= 3'h0;
            irq_en_q    <= 3'h0;
            irq_q       <= 1'b0;
            reg_rdata_q <= hid_pkg::RESET_WORD;
        end else begin
            irq_st_q    <= (irq_st_q & ~(wr_clr ? reg_wdata[2:0] : 3'h0)) | irq_ev;
            irq_en_q    <= wr_en ? reg_wdata[2:0] : irq_en_q;
            irq_q       <= |(irq_st_q & irq_en_q);
            reg_rdata_q <= reg_rd ? rd_mux : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    // A descriptor starts from either flag; a halt or a retire ends it.
    chk_active_as_valid: assert property (
        (state_q == HID_IDLE && active_bit && !valid_bit && !halted) |=> state_q == HID_WAIT)
        else $error("Active flag did not start execution.");

    chk_valid_starts: assert property (
        (state_q == HID_IDLE && valid_bit && !active_bit && !halted) |=> state_q == HID_WAIT)
        else $error("Valid flag did not start execution.");

    chk_no_exec_dead: assert property (
        (state_q == HID_IDLE && !live) |=> state_q == HID_IDLE)
        else $error("Execution began without valid or active.");

    chk_halt_clears_valid: assert property (
        stall_ev |=> (halted && !valid_bit && !active_bit))
        else $error("Stall did not halt and invalidate the descriptor.");

    chk_stall_idles: assert property (
        stall_ev |=> state_q == HID_IDLE)
        else $error("Packets continued after a stall.");

    chk_halt_holds_idle: assert property (
        (state_q == HID_IDLE && halted) |=> state_q == HID_IDLE)
        else $error("A halted descriptor started again.");

    chk_retire_valid: assert property (
        retire |=> !valid_bit)
        else $error("Valid not cleared on retire.");

    // The request handed to the link carries the descriptor fields unchanged.
    chk_split_copy: assert property (
        take_slot |=> xact_q.split == $past(dw1_q[hid_pkg::DW1_SPLIT_BIT]))
        else $error("Split selection not passed on.");

    chk_token_copy: assert property (
        take_slot |=> xact_q.token == $past(dw1_q[hid_pkg::DW1_TOKEN_LSB +: 2]))
        else $error("Token not passed on.");

    chk_addr_copy: assert property (
        take_slot |=> xact_q.function_addr == $past(dw1_q[hid_pkg::DW1_FADDR_LSB +: 7]))
        else $error("Function address not passed on.");

    chk_endpoint_join: assert property (
        take_slot |=> xact_q.endpoint ==
            $past({dw1_q[hid_pkg::DW1_EPHIGH_LSB +: 3], dw0_q[hid_pkg::DW0_EPLOW_BIT]}))
        else $error("Endpoint number formed wrongly.");

    chk_buffer_copy: assert property (
        take_slot |=> xact_q.buffer_start_word == $past(dw2_q[hid_pkg::DW2_BUF_LSB +: 16]))
        else $error("Buffer start not passed on.");

    chk_req_pulse: assert property (
        (state_q == HID_SEND) |=> xact_req_q ##1 !xact_req_q)
        else $error("Request not a single pulse.");

    // Slots, the packet limit and what each packet writes back.
    chk_slot_source: assert property (
        slot_hit |-> $past(microframe_enable_mask[bus_uframe] && desc_frame == bus_frame))
        else $error("Slot taken outside an enabled microframe.");

    chk_mask_cleared: assert property (
        slot_end |=> !dw4_q[$past(xact_q.uframe)])
        else $error("Slot enable not cleared after its slot.");

    chk_mult_limit: assert property (
        got_res |-> {1'b0, pkt_cnt_q} < ((mult == 2'h0) ? 3'h1 : {1'b0, mult}))
        else $error("Packet count exceeded multiplier.");

    chk_byte_writeback: assert property (
        got_res |=> dw3_q[hid_pkg::DW3_COUNT_LSB +: 15] == $past(acc_next))
        else $error("Byte count not written back.");

    chk_result_slot: assert property (
        got_res |=> dw4_q[hid_pkg::DW4_RESULT_LSB + 3 * $past(xact_q.uframe) +: 3] ==
            $past(xact_res.microframe_result))
        else $error("Microframe result not written back.");

    // Main scenarios: a finished IN, a multi-packet OUT, a stall, a kind-1 endpoint request, a split IN.
    cov_in_done: cover property (finish_ev && xact_q.token == hid_pkg::TOKEN_IN);
    cov_out_multi: cover property (more_pkt && xact_q.token == hid_pkg::TOKEN_OUT);
    cov_stall: cover property (stall_ev);
    cov_iso_kind: cover property (xact_req_q && endpoint_kind == 2'h1);
    cov_split_in: cover property (
        xact_req_q && xact_q.split && xact_q.token == hid_pkg::TOKEN_IN);

endmodule : hid_engine

// >>> testbench/hid_link_model.sv
// Behavioural stand-in for the link engine that answers the descriptor engine's requests.
module hid_link_model (
    // Clock and reset.
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    // Link engine request and answer.
    input  wire hid_pkg::hid_xact_t   xact_q,
    input  wire logic                 xact_req,
    output logic                      xact_done,
    output hid_pkg::hid_result_t      xact_res,
    // Behaviour chosen by the bench.
    input  wire logic [3:0]           cfg_delay,
    input  wire logic                 cfg_stall,
    input  wire logic [2:0]           cfg_result,
    input  wire logic [11:0]          cfg_bytes,
    // Observation.
    output logic [7:0]                req_count,
    output logic [7:0]                done_count,
    output hid_pkg::hid_xact_t        seen_xact
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       busy_q;
    logic [3:0] wait_q;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Accept one packet at a time, answer after the chosen delay.
    // Outside the answer cycle the result toggles every cycle, so a stale sample shows up.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_q     <= 1'b0;
            wait_q     <= 4'h0;
            xact_done  <= 1'b0;
            xact_res   <= '0;
            req_count  <= 8'h00;
            done_count <= 8'h00;
            seen_xact  <= '0;
        end else begin
            xact_done <= 1'b0;
            xact_res  <= ~xact_res;
            if (xact_req && !busy_q) begin
                busy_q    <= 1'b1;
                wait_q    <= cfg_delay;
                req_count <= req_count + 8'h01;
                seen_xact <= xact_q;
            end else if (busy_q && wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end else if (busy_q) begin
                busy_q     <= 1'b0;
                xact_done  <= 1'b1;
                done_count <= done_count + 8'h01;
                xact_res   <= {cfg_stall, cfg_result, cfg_bytes, 1'b0};
            end
        end
    end
endmodule : hid_link_model

// >>> testbench/hid_engine_tb_top.sv
// Self-checking bench for the descriptor engine.
module hid_engine_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 clk_sys     = 1'b0;
    logic                 rst_n       = 1'b0;
    logic [3:0]           reg_addr    = 4'h0;
    logic [31:0]          reg_wdata   = 32'h0;
    logic                 reg_wr      = 1'b0;
    logic                 reg_rd      = 1'b0;
    logic [4:0]           bus_frame   = 5'h00;
    logic [2:0]           bus_uframe  = 3'h0;
    logic                 uframe_tick = 1'b0;
    logic [3:0]           cfg_delay   = 4'h2;
    logic                 cfg_stall   = 1'b0;
    logic [2:0]           cfg_result  = 3'h0;
    logic [11:0]          cfg_bytes   = 12'h000;
    logic [31:0]          reg_rdata_q;
    logic                 xact_req_q;
    logic                 xact_done;
    logic                 irq_q;
    logic [7:0]           req_count;
    logic [7:0]           done_count;
    hid_pkg::hid_xact_t   xact_q;
    hid_pkg::hid_xact_t   seen_xact;
    hid_pkg::hid_result_t xact_res;
    int                   failures     = 0;
    int                   total_checks = 0;
    int                   exp_pk       = 0;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Clock and the two parties.
    always #20 clk_sys = ~clk_sys;

    hid_engine hid_engine_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .bus_frame(bus_frame), .bus_uframe(bus_uframe), .uframe_tick(uframe_tick),
        .xact_q(xact_q), .xact_req_q(xact_req_q), .xact_done(xact_done),
        .xact_res(xact_res), .irq_q(irq_q));

    hid_link_model hid_link_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .xact_q(xact_q),
        .xact_req(xact_req_q), .xact_done(xact_done), .xact_res(xact_res),
        .cfg_delay(cfg_delay), .cfg_stall(cfg_stall), .cfg_result(cfg_result),
        .cfg_bytes(cfg_bytes), .req_count(req_count), .done_count(done_count),
        .seen_xact(seen_xact));

    ////////////////////////////////////////////////////////////////////////////////////////
    // Shared compare, bus cycles and slot trigger.
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample mid-cycle there.
    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(64'(reg_rdata_q), 64'(exp));
    endtask : rdchk

    task automatic prog(input logic v, input logic a, input logic [1:0] mult,
                        input logic [1:0] tok, input logic [3:0] ep, input logic [6:0] fa,
                        input logic s, input logic [7:0] frm, input logic [15:0] bw,
                        input logic [7:0] mask);
        wr(hid_pkg::REG_CTRL, 32'h0);
        wr(hid_pkg::REG_DW0, {ep[0], mult, 28'h0, v});
        wr(hid_pkg::REG_DW2, {8'h00, bw, frm});
        wr(hid_pkg::REG_DW4, {24'h0, mask});
        wr(hid_pkg::REG_CTRL, 32'h1);
        wr(hid_pkg::REG_DW1, {17'h0, s, 2'h1, tok, fa, ep[3:1]});
        wr(hid_pkg::REG_DW3, {a, 31'h0});
        wr(hid_pkg::REG_CTRL, 32'h0);
    endtask : prog

    // A bounded wait for the packets, then a margin in which surplus packets would appear.
    task automatic fire(input logic [4:0] f, input logic [2:0] u, input int npk);
        int n;
        exp_pk += npk;
        @(posedge clk_sys);
        bus_frame   <= f;
        bus_uframe  <= u;
        uframe_tick <= 1'b1;
        @(posedge clk_sys);
        uframe_tick <= 1'b0;
        n = 0;
        while (int'(done_count) != exp_pk && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (12) @(posedge clk_sys);
        chk(64'(req_count), 64'(exp_pk));
    endtask : fire

    ////////////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_regs;
        rdchk(hid_pkg::REG_DW0, 32'h0);
        wr(hid_pkg::REG_IRQ_ST, 32'h7);
        rdchk(hid_pkg::REG_IRQ_ST, 32'h0);
        wr(4'hF, 32'hFFFF_FFFF);
        rdchk(4'hF, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_out_hs;
        logic [15:0] bw;
        bw = 16'((32'h0000_1400 - 32'h0000_0400) >> 3);
        @(posedge clk_sys);
        cfg_result <= 3'h4;
        cfg_bytes  <= 12'h0C8;
        wr(hid_pkg::REG_IRQ_EN, 32'h1);
        prog(1'b1, 1'b0, 2'h1, hid_pkg::TOKEN_OUT, 4'h9, 7'h35, 1'b0, 8'h18, bw, 8'h04);
        fire(5'h03, 3'h2, 1);
        chk(64'(seen_xact), 64'({1'b0, 2'h0, 7'h35, 4'h9, bw, 3'h2}));
        rdchk(hid_pkg::REG_DW0, {1'b1, 2'h1, 29'h0});
        rdchk(hid_pkg::REG_DW4, 32'h0001_0000);
        wr(hid_pkg::REG_CTRL, 32'h1);
        rdchk(hid_pkg::REG_DW3, 32'h0000_00C8);
        wr(hid_pkg::REG_CTRL, 32'h0);
        chk(64'(irq_q), 64'(1'b1));
        wr(hid_pkg::REG_IRQ_CL, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk(64'(irq_q), 64'(1'b0));
        $display("test out_hs done");
    endtask : t_out_hs

    task automatic t_in_split;
        @(posedge clk_sys);
        cfg_result <= 3'h2;
        cfg_bytes  <= 12'h100;
        prog(1'b1, 1'b0, 2'h3, hid_pkg::TOKEN_IN, 4'h2, 7'h7F, 1'b1, 8'h57, 16'hFFFF, 8'h02);
        fire(5'h0B, 3'h1, 0);
        fire(5'h0A, 3'h0, 0);
        fire(5'h0A, 3'h1, 3);
        chk(64'(seen_xact), 64'({1'b1, 2'h1, 7'h7F, 4'h2, 16'hFFFF, 3'h1}));
        wr(hid_pkg::REG_CTRL, 32'h1);
        rdchk(hid_pkg::REG_DW3, 32'h0000_0300);
        wr(hid_pkg::REG_CTRL, 32'h0);
        rdchk(hid_pkg::REG_DW4, 32'h0000_1000);
        rdchk(hid_pkg::REG_DW0, {1'b0, 2'h3, 29'h0});
        $display("test in_split done");
    endtask : t_in_split

    task automatic t_stall;
        @(posedge clk_sys);
        cfg_stall  <= 1'b1;
        cfg_result <= 3'h0;
        cfg_bytes  <= 12'h000;
        wr(hid_pkg::REG_IRQ_EN, 32'h0);
        wr(hid_pkg::REG_IRQ_CL, 32'h7);
        prog(1'b0, 1'b0, 2'h2, hid_pkg::TOKEN_OUT, 4'h1, 7'h01, 1'b0, 8'h20, 16'h0010, 8'h01);
        fire(5'h04, 3'h0, 0);
        prog(1'b0, 1'b1, 2'h2, hid_pkg::TOKEN_OUT, 4'h1, 7'h01, 1'b0, 8'h20, 16'h0010, 8'h01);
        fire(5'h04, 3'h0, 1);
        wr(hid_pkg::REG_CTRL, 32'h1);
        rdchk(hid_pkg::REG_DW3, 32'h4000_0000);
        wr(hid_pkg::REG_CTRL, 32'h0);
        chk(64'(irq_q), 64'(1'b0));
        wr(hid_pkg::REG_IRQ_EN, 32'h2);
        repeat (2) @(posedge clk_sys);
        chk(64'(irq_q), 64'(1'b1));
        rdchk(hid_pkg::REG_IRQ_ST, 32'h2);
        wr(hid_pkg::REG_IRQ_CL, 32'h7);
        $display("test stall done");
    endtask : t_stall

    task automatic t_error;
        @(posedge clk_sys);
        cfg_stall  <= 1'b0;
        cfg_result <= 3'h1;
        wr(hid_pkg::REG_IRQ_EN, 32'h4);
        prog(1'b1, 1'b0, 2'h1, hid_pkg::TOKEN_IN, 4'h3, 7'h10, 1'b0, 8'hF8, 16'h0001, 8'h80);
        fire(5'h1F, 3'h7, 1);
        rdchk(hid_pkg::REG_DW0, {1'b1, 2'h1, 29'h0});
        rdchk(hid_pkg::REG_DW4, 32'h2000_0000);
        rdchk(hid_pkg::REG_IRQ_ST, 32'h4);
        chk(64'(irq_q), 64'(1'b1));
        $display("test error done");
    endtask : t_error

    ////////////////////////////////////////////////////////////////////////////////////////
    // Verdict, main sequence and watchdog.
    task automatic summarize;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_out_hs();
        t_in_split();
        t_stall();
        t_error();
        summarize();
    end

    // The tests need a few hundred cycles; twenty thousand leaves ample slack.
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        summarize();
    end
endmodule : hid_engine_tb_top
